//--- rtl/spt_pkg.sv
// Constants, types and carriers for the parallel slave port block
package spt_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_DATA = 8'h08;
  localparam logic [7:0] IDX_CTRL_PINS = 8'h09;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_STATUS_DIR = 8'h89;
  localparam logic [7:0] IDX_IRQ_EN = 8'h8c;
  localparam logic [7:0] IDX_ANALOG_CFG = 8'h9f;
  localparam logic [7:0] IDX_DATA_DIR = 8'h40;

  // Field positions
  localparam int STS_IN_FULL_BIT = 7;
  localparam int STS_OUT_FULL_BIT = 6;
  localparam int STS_OVERFLOW_BIT = 5;
  localparam int STS_MODE_BIT = 4;
  localparam int IRQ_FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 7;

  // Reset values
  localparam logic [7:0] RST_STATUS_DIR = 8'h07;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [2:0] RST_ANALOG_CFG = 3'h0;
  localparam logic [7:0] RST_DATA_DIR = 8'hff;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [2:0] RST_PINS_IDLE = 3'h7;

  // Pin drive levels
  localparam logic [7:0] OE_ALL = 8'hff;
  localparam logic [7:0] OE_NONE = 8'h00;

  // Internal clock phases, four per instruction cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h3,
    PH_Q4 = 2'h2
  } spt_phase_e;

  // Completion timer: wait for Q2, then for Q4
  typedef enum logic [1:0] {
    EVT_IDLE = 2'h0,
    EVT_WAIT_Q2 = 2'h1,
    EVT_WAIT_Q4 = 2'h3
  } spt_evt_e;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_PORT_DATA,
    SEL_CTRL_PINS,
    SEL_IRQ_FLAGS,
    SEL_STATUS_DIR,
    SEL_IRQ_EN,
    SEL_ANALOG_CFG,
    SEL_DATA_DIR
  } spt_sel_e;

  // Pin carriers; control bits are {chip select, write, read}, all low active
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [7:0] data;
  } spt_pins_in_s;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe;
  } spt_pins_out_s;

endpackage

//--- rtl/spt_top.sv
// Parallel slave port with AXI4-Lite register access
//
// Behaviour
// - Mode bit set turns data port into 8-bit slave port under external strobes.
// - One address: firmware writes output latch, reads input latch.
// - In slave mode data direction register is ignored; strobes steer pins.
// - External write while select and write low; firmware sees live pins.
// - Select or write going high latches data pins into input latch.
// - Write completion sets input-full and irq flag at Q4 after next Q2.
// - Firmware read of data port clears input-full flag.
// - External write while input-full set raises overflow flag.
// - Overflowing write replaces unread input latch value.
// - Select and read low: output latch driven onto data pins.
// - Output-full clears as soon as an external read begins.
// - Firmware write during external read shows at once; output-full stays clear.
// - Read end releases pins, sets irq flag at Q4 after next Q2.
// - Output-full stays low after a read until firmware writes again.
// - Firmware write to output latch sets output-full.
// - Mode off holds both full flags clear; overflow keeps its value.
// - Irq flag cleared only by firmware; enable bit gates the request.
`timescale 1ns/1ps
`default_nettype none

module spt_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [spt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [spt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External microprocessor pins
  input wire spt_pkg::spt_pins_in_s pins_i,
  output spt_pkg::spt_pins_out_s pins_o,
  // Gated interrupt request
  output logic irq_req
);

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic wr_act;
    logic rd_act;
    logic [7:0] data_hold;
    logic [7:0] data_d1;
    logic [7:0] data_d2;
    logic [7:0] in_latch;
    logic [7:0] out_latch;
    logic in_buffer_full;
    logic out_buffer_full;
    logic in_buffer_overflow;
    logic mode;
    logic [2:0] ctl_dir;
    logic [2:0] analog_cfg;
    logic [7:0] data_dir;
    logic irq_flag;
    logic irq_en;
    spt_pkg::spt_phase_e phase;
    spt_pkg::spt_evt_e wr_evt;
    spt_pkg::spt_evt_e rd_evt;
    logic [7:0] pin_oe;
    logic irq_req;
    logic aw_have;
    logic w_have;
    logic [spt_pkg::ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spt_state_s;

  spt_state_s s;
  spt_state_s next_s;

  // Word-aligned index decode, shared by both channels
  function automatic spt_pkg::spt_sel_e reg_sel(input logic [spt_pkg::ADDR_W-1:0] addr);
    spt_pkg::spt_sel_e sel;
    sel = spt_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0 && addr[spt_pkg::ADDR_W-1:10] == 2'h0) begin
      unique case (addr[9:2])
        spt_pkg::IDX_PORT_DATA: sel = spt_pkg::SEL_PORT_DATA;
        spt_pkg::IDX_CTRL_PINS: sel = spt_pkg::SEL_CTRL_PINS;
        spt_pkg::IDX_IRQ_FLAGS: sel = spt_pkg::SEL_IRQ_FLAGS;
        spt_pkg::IDX_STATUS_DIR: sel = spt_pkg::SEL_STATUS_DIR;
        spt_pkg::IDX_IRQ_EN: sel = spt_pkg::SEL_IRQ_EN;
        spt_pkg::IDX_ANALOG_CFG: sel = spt_pkg::SEL_ANALOG_CFG;
        spt_pkg::IDX_DATA_DIR: sel = spt_pkg::SEL_DATA_DIR;
        default: sel = spt_pkg::SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // Completion timer step, one per transfer direction
  function automatic spt_pkg::spt_evt_e evt_step(input spt_pkg::spt_evt_e evt,
                                                 input logic start,
                                                 input spt_pkg::spt_phase_e ph);
    spt_pkg::spt_evt_e nx;
    nx = evt;
    unique case (evt)
      spt_pkg::EVT_IDLE: nx = evt;
      spt_pkg::EVT_WAIT_Q2: nx = (ph == spt_pkg::PH_Q2) ? spt_pkg::EVT_WAIT_Q4 : evt;
      spt_pkg::EVT_WAIT_Q4: nx = (ph == spt_pkg::PH_Q4) ? spt_pkg::EVT_IDLE : evt;
      default: nx = spt_pkg::EVT_IDLE;
    endcase
    if (start) begin
      nx = spt_pkg::EVT_WAIT_Q2;
    end
    return nx;
  endfunction

  logic wr_now;
  logic rd_now;
  logic wr_end;
  logic rd_end;
  logic wr_fire;
  logic rd_fire;
  logic do_write;
  logic do_read;
  spt_pkg::spt_sel_e wsel;
  spt_pkg::spt_sel_e rsel;
  logic [7:0] rval;

  always_comb begin
    next_s = s;
    // First stage feeds only the second
    next_s.sync1 = {pins_i.cs_n, pins_i.wr_n, pins_i.rd_n};
    next_s.sync2 = s.sync1;
    unique case (s.phase)
      spt_pkg::PH_Q1: next_s.phase = spt_pkg::PH_Q2;
      spt_pkg::PH_Q2: next_s.phase = spt_pkg::PH_Q3;
      spt_pkg::PH_Q3: next_s.phase = spt_pkg::PH_Q4;
      spt_pkg::PH_Q4: next_s.phase = spt_pkg::PH_Q1;
    endcase

    // Strobe levels, qualified by mode
    wr_now = s.mode && !s.sync2[2] && !s.sync2[1];
    rd_now = s.mode && !s.sync2[2] && !s.sync2[0];
    wr_end = s.wr_act && !wr_now;
    rd_end = s.rd_act && !rd_now;
    next_s.wr_act = wr_now;
    next_s.rd_act = rd_now;
    // Data delayed to match the strobe synchroniser, so a released bus is never taken
    next_s.data_d1 = pins_i.data;
    next_s.data_d2 = s.data_d1;
    if (wr_now) begin
      next_s.data_hold = s.data_d2;
    end
    wr_fire = (s.wr_evt == spt_pkg::EVT_WAIT_Q4) && (s.phase == spt_pkg::PH_Q4);
    rd_fire = (s.rd_evt == spt_pkg::EVT_WAIT_Q4) && (s.phase == spt_pkg::PH_Q4);
    next_s.wr_evt = evt_step(s.wr_evt, wr_end, s.phase);
    next_s.rd_evt = evt_step(s.rd_evt, rd_end, s.phase);

    // Write channels taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    do_write = s.aw_have && s.w_have && !s.bvalid;
    wsel = reg_sel(s.awaddr);
    if (do_write) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = (wsel == spt_pkg::SEL_NONE) ? spt_pkg::RESP_SLVERR : spt_pkg::RESP_OKAY;
      if (s.wstrb0) begin
        unique case (wsel)
          spt_pkg::SEL_PORT_DATA: begin
            next_s.out_latch = s.wdata;
            next_s.out_buffer_full = 1'b1;
          end
          spt_pkg::SEL_IRQ_FLAGS: next_s.irq_flag = s.wdata[spt_pkg::IRQ_FLAG_BIT];
          spt_pkg::SEL_STATUS_DIR: begin
            next_s.in_buffer_overflow = s.wdata[spt_pkg::STS_OVERFLOW_BIT];
            next_s.mode = s.wdata[spt_pkg::STS_MODE_BIT];
            next_s.ctl_dir = s.wdata[2:0];
          end
          spt_pkg::SEL_IRQ_EN: next_s.irq_en = s.wdata[spt_pkg::IRQ_EN_BIT];
          spt_pkg::SEL_ANALOG_CFG: next_s.analog_cfg = s.wdata[2:0];
          spt_pkg::SEL_DATA_DIR: next_s.data_dir = s.wdata;
          default: next_s.bresp = spt_pkg::RESP_SLVERR;
        endcase
      end
    end

    // Read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    do_read = s_axi_arvalid && s.arready;
    rsel = reg_sel(s_axi_araddr);
    rval = 8'h00;
    unique case (rsel)
      // Live pins during a held external write
      spt_pkg::SEL_PORT_DATA: rval = wr_now ? pins_i.data : s.in_latch;
      spt_pkg::SEL_CTRL_PINS: rval = {5'h00, s.sync2};
      spt_pkg::SEL_IRQ_FLAGS: rval = {s.irq_flag, 7'h00};
      spt_pkg::SEL_STATUS_DIR: rval = {s.in_buffer_full, s.out_buffer_full,
                                       s.in_buffer_overflow, s.mode, 1'b0, s.ctl_dir};
      spt_pkg::SEL_IRQ_EN: rval = {s.irq_en, 7'h00};
      spt_pkg::SEL_ANALOG_CFG: rval = {5'h00, s.analog_cfg};
      spt_pkg::SEL_DATA_DIR: rval = s.data_dir;
      default: rval = 8'h00;
    endcase
    if (do_read) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = {24'h000000, rval};
      next_s.rresp = (rsel == spt_pkg::SEL_NONE) ? spt_pkg::RESP_SLVERR : spt_pkg::RESP_OKAY;
      if (rsel == spt_pkg::SEL_PORT_DATA) begin
        next_s.in_buffer_full = 1'b0;
      end
    end

    // Pin events after software so that a pin event beats a firmware access
    if (wr_end) begin
      next_s.in_latch = s.data_hold;
      if (s.in_buffer_full || s.wr_evt != spt_pkg::EVT_IDLE) begin
        next_s.in_buffer_overflow = 1'b1;
      end
    end
    if (wr_fire) begin
      next_s.in_buffer_full = 1'b1;
      next_s.irq_flag = 1'b1;
    end
    if (rd_fire) begin
      next_s.irq_flag = 1'b1;
    end
    if (rd_now) begin
      next_s.out_buffer_full = 1'b0;
    end
    if (!next_s.mode) begin
      next_s.in_buffer_full = 1'b0;
      next_s.out_buffer_full = 1'b0;
    end

    // Direction register only matters outside slave mode
    next_s.pin_oe = s.mode ? (rd_now ? spt_pkg::OE_ALL : spt_pkg::OE_NONE)
                           : ~s.data_dir;
    next_s.irq_req = next_s.irq_flag && next_s.irq_en;
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.sync1 <= spt_pkg::RST_PINS_IDLE;
      s.sync2 <= spt_pkg::RST_PINS_IDLE;
      s.in_latch <= spt_pkg::RST_LATCH;
      s.out_latch <= spt_pkg::RST_LATCH;
      s.in_buffer_full <= spt_pkg::RST_STATUS_DIR[spt_pkg::STS_IN_FULL_BIT];
      s.out_buffer_full <= spt_pkg::RST_STATUS_DIR[spt_pkg::STS_OUT_FULL_BIT];
      s.in_buffer_overflow <= spt_pkg::RST_STATUS_DIR[spt_pkg::STS_OVERFLOW_BIT];
      s.mode <= spt_pkg::RST_STATUS_DIR[spt_pkg::STS_MODE_BIT];
      s.ctl_dir <= spt_pkg::RST_STATUS_DIR[2:0];
      s.analog_cfg <= spt_pkg::RST_ANALOG_CFG;
      s.data_dir <= spt_pkg::RST_DATA_DIR;
      s.irq_flag <= spt_pkg::RST_IRQ_FLAGS[spt_pkg::IRQ_FLAG_BIT];
      s.irq_en <= spt_pkg::RST_IRQ_EN[spt_pkg::IRQ_EN_BIT];
      s.phase <= spt_pkg::PH_Q1;
      s.wr_evt <= spt_pkg::EVT_IDLE;
      s.rd_evt <= spt_pkg::EVT_IDLE;
      s.pin_oe <= spt_pkg::OE_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign pins_o = {s.out_latch, s.pin_oe};
  assign irq_req = s.irq_req;

endmodule

`default_nettype wire

//--- sim/spt_top_sva.sv
// Assertions on the slave port pins and register bus
`timescale 1ns/1ps
`default_nettype none
module spt_top_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Pins and request
  input wire spt_pkg::spt_pins_in_s pins_i,
  input wire spt_pkg::spt_pins_out_s pins_o,
  input wire logic irq_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_read_drive: assert property (
    (!pins_i.cs_n && !pins_i.rd_n) [*5] |-> pins_o.oe == 8'hff)
    else $error("pins not driven in read");
  chk_read_release: assert property (
    $rose(pins_i.rd_n) |-> ##[1:4] pins_o.oe == 8'h00)
    else $error("pins still driven");
  chk_drive_cause: assert property (
    $rose(pins_o.oe[0]) |-> !$past(pins_i.rd_n, 2) && !$past(pins_i.cs_n, 2))
    else $error("drive without read");
  chk_latch_source: assert property (
    $changed(pins_o.data) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("output latch changed alone");
  chk_irq_drop: assert property (
    $fell(irq_req) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("request dropped alone");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response held");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  chk_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  cover property (pins_o.oe == 8'hff);
  cover property ($rose(irq_req));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h0);
endmodule
bind spt_top spt_top_sva chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .pins_i(pins_i), .pins_o(pins_o), .irq_req(irq_req));
`default_nettype wire

//--- sim/spt_host_model.sv
// External byte-wide bus master on the slave port pins
`timescale 1ns/1ps
`default_nettype none
module spt_host_model (
  // Clock
  input wire logic aclk,
  // Device pins
  input wire spt_pkg::spt_pins_out_s pins_o,
  output var spt_pkg::spt_pins_in_s pins_i
);
  logic [2:0] ctl = 3'h7;
  logic [7:0] drv = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic [7:0] bus;
  always @(posedge aclk) cnt <= cnt + 8'h01;
  // Released bus wanders so a stale byte never passes for data
  assign bus = (pins_o.oe & pins_o.data) | (~pins_o.oe & (ctl[1] ? ~cnt : drv));
  assign pins_i = {ctl, bus};
  // One transfer, strobes low for hold cycles (4 or more)
  task automatic xfer(input logic rd, input logic [7:0] b, input int hold, output logic [7:0] q);
    drv <= b;
    ctl <= {1'b0, rd, !rd};
    repeat (hold) @(posedge aclk);
    q = bus;
    ctl <= 3'h7;
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the slave port block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic wr; logic [11:0] a; logic [7:0] d; logic [1:0] r;} spt_row_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid, irq_req;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  spt_pkg::spt_pins_in_s pins_i;
  spt_pkg::spt_pins_out_s pins_o;
  logic [7:0] q;
  int num_errors = 0;
  int cmp_count = 0;
  spt_row_s rows [11] = '{'{1'b0, 12'h224, 8'h07, 2'h0}, '{1'b0, 12'h030, 8'h00, 2'h0},
    '{1'b0, 12'h230, 8'h00, 2'h0}, '{1'b0, 12'h27c, 8'h00, 2'h0}, '{1'b0, 12'h024, 8'h07, 2'h0},
    '{1'b0, 12'h020, 8'h00, 2'h0}, '{1'b0, 12'h004, 8'h00, 2'h2}, '{1'b1, 12'h230, 8'h80, 2'h0},
    '{1'b0, 12'h230, 8'h80, 2'h0},
    '{1'b1, 12'h224, 8'h17, 2'h0}, '{1'b0, 12'h224, 8'h17, 2'h0}};
  always #50 aclk = ~aclk;
  spt_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .pins_i(pins_i), .pins_o(pins_o), .irq_req(irq_req));
  spt_host_model host (.aclk(aclk), .pins_o(pins_o), .pins_i(pins_i));
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hung(input int n);
    if (n == 40) begin
      num_errors++;
      $display("[ERR] %0t bus hang", $time);
      finish_test();
    end
  endtask
  // Ready lines stay high, so every answer is taken at once
  task automatic axw(input logic [11:0] a, input logic [7:0] d);
    int n;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    hung(n);
    chk({30'h0, bresp}, 32'h0);
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    hung(n);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    rst();
    foreach (rows[i]) begin
      if (rows[i].wr) axw(rows[i].a, rows[i].d);
      else axr(rows[i].a, {24'h000000, rows[i].d}, rows[i].r);
    end
    $display("register table done");
    host.xfer(1'b0, 8'ha5, 4, q);
    repeat (10) @(posedge aclk);
    axr(12'h224, 32'h97, 2'h0);
    chk({31'h0, irq_req}, 32'h1);
    host.xfer(1'b0, 8'h3c, 12, q);
    repeat (10) @(posedge aclk);
    axr(12'h224, 32'hb7, 2'h0);
    axr(12'h020, 32'h3c, 2'h0);
    axr(12'h224, 32'h37, 2'h0);
    axw(12'h224, 8'h17);
    axr(12'h224, 32'h17, 2'h0);
    axw(12'h030, 8'h00);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_req}, 32'h0);
    $display("external write done");
    axw(12'h020, 8'h5a);
    axr(12'h224, 32'h57, 2'h0);
    host.xfer(1'b1, 8'h00, 8, q);
    chk({24'h0, q}, 32'h5a);
    repeat (10) @(posedge aclk);
    axr(12'h224, 32'h17, 2'h0);
    axr(12'h030, 32'h80, 2'h0);
    chk({31'h0, irq_req}, 32'h1);
    axw(12'h230, 8'h00);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_req}, 32'h0);
    axw(12'h230, 8'h80);
    axw(12'h020, 8'h11);
    fork
      host.xfer(1'b1, 8'h00, 20, q);
      begin
        repeat (6) @(posedge aclk);
        axw(12'h020, 8'hc3);
      end
    join
    chk({24'h0, q}, 32'hc3);
    axr(12'h224, 32'h17, 2'h0);
    $display("external read done");
    axw(12'h100, 8'h00);
    repeat (3) @(posedge aclk);
    chk({24'h0, pins_o.oe}, 32'h0);
    axw(12'h100, 8'hff);
    axw(12'h020, 8'h66);
    axw(12'h224, 8'h27);
    host.xfer(1'b0, 8'h77, 4, q);
    repeat (10) @(posedge aclk);
    axr(12'h224, 32'h27, 2'h0);
    $display("mode off done");
    rst();
    axr(12'h230, 32'h00, 2'h0);
    chk({31'h0, irq_req}, 32'h0);
    $display("second reset done");
    finish_test();
  end
endmodule
`default_nettype wire
